// *** hdl/ea_consts.svh ***
`ifndef EA_CONSTS_SVH
`define EA_CONSTS_SVH
`define EA_SECTOR_BITS 9
`define EA_PROT_LO 15'h0001
`define EA_PROT_HI 15'h000F
`define EA_PFAIL_VEC 15'h0030
`define EA_INTR_LINK 15'h0033
`define EA_LOCKOUT_LEVELS 4'h8
`define EA_BASE_HALF_MASK 15'h3FFF
`define EA_LDX_OPCODE 4'hD
`define EA_JST_OPCODE 4'h2
`endif

// *** hdl/ea_pkg.sv ***
package ea_pkg;
	typedef struct packed {
		logic indirect;
		logic index;
		logic [3:0] opcode;
		logic sector;
		logic [8:0] offset;
	} memref_t;
	typedef struct packed {
		logic [5:0] opcode;
		logic [3:0] func;
		logic [5:0] device;
	} io_fmt_t;
	typedef struct packed {
		logic [9:0] opcode;
		logic [5:0] neg_count;
	} shift_fmt_t;
	typedef struct packed {
		logic sign;
		logic [14:0] mag;
	} data_word_t;
	typedef struct packed {
		logic [14:0] addr;
		logic valid;
		logic write_ok;
	} ea_result_t;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_INDIRECT, ST_DONE} ea_state_t;
endpackage : ea_pkg

// *** hdl/field_split.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ea_consts.svh"
// Splits an instruction word into its format views; index 0 is bit 16.
module field_split (
	input wire logic [15:0] word,
	output ea_pkg::memref_t mr,
	output ea_pkg::io_fmt_t io,
	output ea_pkg::shift_fmt_t sh,
	output logic [15:0] generic_op,
	output logic [5:0] shift_count
);
	assign mr = ea_pkg::memref_t'(word);
	assign io = ea_pkg::io_fmt_t'(word);
	assign sh = ea_pkg::shift_fmt_t'(word);
	assign generic_op = word;
	assign shift_count = 6'(-sh.neg_count);
endmodule : field_split
`default_nettype wire

// *** hdl/dword_join.sv ***
`timescale 1ns/1ps
`default_nettype none
// Joins a double-precision pair into a 31-bit signed value.
module dword_join (
	input wire logic [15:0] hi_word,
	input wire logic [15:0] lo_word,
	output logic [30:0] value,
	output logic lo_sign_ok
);
	ea_pkg::data_word_t hi, lo;
	assign hi = ea_pkg::data_word_t'(hi_word);
	assign lo = ea_pkg::data_word_t'(lo_word);
	assign value = {hi.sign, hi.mag, lo.mag};
	assign lo_sign_ok = ~lo.sign;
endmodule : dword_join
`default_nettype wire

// *** hdl/effective_address_former.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ea_consts.svh"
module effective_address_former #(
	parameter bit LOCKOUT = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic fetch,
	input wire logic [15:0] instr,
	input wire logic [14:0] pc,
	input wire logic [15:0] x_reg,
	input wire logic mem_valid,
	input wire logic [15:0] mem_data,
	input wire logic mode_set,
	input wire logic mode_clr,
	input wire logic interrupt,
	input wire logic power_fail,
	input wire logic panel_access,
	input wire logic store_req,
	input wire logic [14:0] store_addr,
	input wire logic [15:0] dp_hi,
	input wire logic [15:0] dp_lo,
	output logic [14:0] ea_q,
	output logic ea_valid_q,
	output logic ind_req_q,
	output logic [14:0] ind_addr_q,
	output logic lockout_err_q,
	output logic store_ok_q,
	output logic addr_extend_mode_ff,
	output logic prior_mode_indicator,
	output logic index_to_sum_enable,
	output logic addr_reg_extra_bit,
	output logic [14:0] vector_q,
	output logic [3:0] opcode_q,
	output logic [5:0] shift_count_q,
	output logic [30:0] dp_value_q,
	output logic dp_ok_q
);
	ea_pkg::memref_t mr, mw;
	ea_pkg::ea_state_t state_q;
	logic [15:0] orig_q;
	logic [3:0] level_q;
	logic pc_bit2_copy;
	logic [5:0] sc;
	logic [30:0] dpv;
	logic dpok;
	logic [14:0] base;
	logic [14:0] sum;
	logic mem_word_bit2, pc_extra_bit, mem_bit2_index_gate, icycle_bit2_block;
	logic pc_bit2_substitute, jump_store_op, load_index_op, idx_gate;
	logic step_indirect;
	logic [14:0] idx_sum;
	logic [14:0] wa;

	field_split u_split (
		.word(instr),
		.mr(mr),
		.io(),
		.sh(),
		.generic_op(),
		.shift_count(sc)
	);
	dword_join u_dw (
		.hi_word(dp_hi),
		.lo_word(dp_lo),
		.value(dpv),
		.lo_sign_ok(dpok)
	);

	assign mw = ea_pkg::memref_t'(mem_data);
	assign mem_word_bit2 = mw.index;
	assign pc_extra_bit = pc[14];
	assign jump_store_op = orig_q[13:10] == `EA_JST_OPCODE;
	assign load_index_op = orig_q[13:10] == `EA_LDX_OPCODE;
	assign icycle_bit2_block = ~addr_extend_mode_ff;
	assign pc_bit2_substitute = addr_extend_mode_ff;
	// The word in hand asks for a further indirect level, so in extended mode indexing must wait.
	assign step_indirect = (state_q == ea_pkg::ST_INDIRECT) ? mw.indirect : orig_q[15];

	// Index step decision for the step in progress.
	always_comb begin
		if (addr_extend_mode_ff) begin
			mem_bit2_index_gate = orig_q[14];
			idx_gate = mem_bit2_index_gate & ~step_indirect
				& ~(load_index_op & orig_q[15]);
		end else begin
			mem_bit2_index_gate = (state_q == ea_pkg::ST_INDIRECT) ? mw.index : orig_q[14];
			idx_gate = mem_bit2_index_gate;
		end
	end

	// Address word for the step: indirect words carry bit 2 as address in extended mode, except for the jump-store opcode.
	always_comb begin
		if (state_q == ea_pkg::ST_INDIRECT) begin
			if (!icycle_bit2_block && !jump_store_op)
				wa = {mem_word_bit2, mem_data[13:0]};
			else
				wa = {addr_reg_extra_bit, mem_data[13:0]};
		end else if (orig_q[9]) begin
			wa = {addr_reg_extra_bit, pc[13:9], orig_q[8:0]};
		end else begin
			wa = {addr_reg_extra_bit, 5'h00, orig_q[8:0]};
		end
		if (!addr_extend_mode_ff)
			wa = {addr_reg_extra_bit, wa[13:0]};
	end

	assign base = wa;
	assign idx_sum = idx_gate ? 15'(base + x_reg[14:0]) : base;
	// In normal mode an index carry must not move the address into the other half.
	assign sum = addr_extend_mode_ff ? idx_sum : {addr_reg_extra_bit, idx_sum[13:0]};

	// Effective address sequencing.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ea_pkg::ST_IDLE;
			orig_q <= 16'h0000;
			level_q <= 4'h0;
			ea_q <= 15'h0000;
			ea_valid_q <= 1'b0;
			ind_req_q <= 1'b0;
			ind_addr_q <= 15'h0000;
			lockout_err_q <= 1'b0;
			index_to_sum_enable <= 1'b0;
		end else begin
			ea_valid_q <= 1'b0;
			unique case (state_q)
				ea_pkg::ST_IDLE: begin
					if (fetch) begin
						orig_q <= instr;
						level_q <= 4'h0;
						lockout_err_q <= 1'b0;
						state_q <= ea_pkg::ST_WAIT;
					end
				end
				ea_pkg::ST_WAIT, ea_pkg::ST_INDIRECT: begin
					if (state_q == ea_pkg::ST_WAIT || mem_valid) begin
						index_to_sum_enable <= idx_gate;
						if ((state_q == ea_pkg::ST_WAIT ? orig_q[15] : mw.indirect)) begin
							if (LOCKOUT && level_q == `EA_LOCKOUT_LEVELS) begin
								lockout_err_q <= 1'b1;
								state_q <= ea_pkg::ST_DONE;
							end else begin
								ind_addr_q <= addr_extend_mode_ff ? base : sum;
								ind_req_q <= 1'b1;
								level_q <= 4'(level_q + 4'h1);
								state_q <= ea_pkg::ST_INDIRECT;
							end
						end else begin
							ind_req_q <= 1'b0;
							ea_q <= sum;
							ea_valid_q <= 1'b1;
							state_q <= ea_pkg::ST_DONE;
						end
					end
				end
				ea_pkg::ST_DONE: begin
					ind_req_q <= 1'b0;
					state_q <= ea_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Mode flip-flop and prior-mode record.
	always_ff @(posedge clk) begin
		if (rst) begin
			addr_extend_mode_ff <= 1'b0;
			prior_mode_indicator <= 1'b0;
		end else if (interrupt | power_fail) begin
			prior_mode_indicator <= addr_extend_mode_ff;
			addr_extend_mode_ff <= 1'b1;
		end else if (mode_set) begin
			addr_extend_mode_ff <= 1'b1;
		end else if (mode_clr) begin
			addr_extend_mode_ff <= 1'b0;
		end
	end

	// Extra address bit tracks the pc copy; only extended mode may move it.
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_bit2_copy <= 1'b0;
			addr_reg_extra_bit <= 1'b0;
		end else if (fetch) begin
			pc_bit2_copy <= pc_bit2_substitute ? pc_extra_bit : pc_bit2_copy;
			addr_reg_extra_bit <= pc_bit2_substitute ? pc_extra_bit : pc_bit2_copy;
		end
	end

	// Store protection, vectors and decoded fields.
	always_ff @(posedge clk) begin
		if (rst) begin
			store_ok_q <= 1'b0;
			vector_q <= 15'h0000;
			opcode_q <= 4'h0;
			shift_count_q <= 6'h00;
			dp_value_q <= 31'h00000000;
			dp_ok_q <= 1'b0;
		end else begin
			store_ok_q <= store_req & (panel_access | store_addr < `EA_PROT_LO
				| store_addr > `EA_PROT_HI);
			vector_q <= power_fail ? `EA_PFAIL_VEC : `EA_INTR_LINK;
			opcode_q <= mr.opcode;
			shift_count_q <= sc;
			dp_value_q <= dpv;
			dp_ok_q <= dpok;
		end
	end

	a_prot_block: assert property (@(posedge clk) disable iff (rst)
		(store_req && !panel_access && store_addr >= `EA_PROT_LO && store_addr <= `EA_PROT_HI)
		|=> !store_ok_q) else $error("protected store allowed");
	a_intr_sets_mode: assert property (@(posedge clk) disable iff (rst)
		interrupt |=> addr_extend_mode_ff) else $error("interrupt did not set mode");
	a_prior_mode: assert property (@(posedge clk) disable iff (rst)
		interrupt |=> prior_mode_indicator == $past(addr_extend_mode_ff))
		else $error("prior mode wrong");
	a_pf_vector: assert property (@(posedge clk) disable iff (rst)
		power_fail |=> vector_q == `EA_PFAIL_VEC) else $error("bad power fail vector");
	a_extra_hold: assert property (@(posedge clk) disable iff (rst)
		(fetch && !addr_extend_mode_ff) |=> $stable(addr_reg_extra_bit))
		else $error("extra bit moved in normal mode");
	a_lock_levels: assert property (@(posedge clk) disable iff (rst)
		level_q <= `EA_LOCKOUT_LEVELS || !LOCKOUT) else $error("too many levels");
	a_ea_done: assert property (@(posedge clk) disable iff (rst)
		ea_valid_q |=> !ea_valid_q ##1 state_q == ea_pkg::ST_IDLE)
		else $error("sequence did not return");
	a_ext_noidx: assert property (@(posedge clk) disable iff (rst)
		(addr_extend_mode_ff && !orig_q[14] && state_q != ea_pkg::ST_IDLE
		&& state_q != ea_pkg::ST_DONE) |=> !index_to_sum_enable || $past(fetch))
		else $error("index gated without tag");
	a_shift_cnt: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> shift_count_q == 6'(-$past(instr[5:0]))) else $error("shift count wrong");
endmodule : effective_address_former
`default_nettype wire

// *** sim/core_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Core memory answering indirect word requests after a programmable delay.
module core_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic [15:0] word_in,
	input wire logic [3:0] lat,
	output logic valid,
	output logic [15:0] data
);
	logic [3:0] cnt_q;
	logic hold_q;
	// A request still standing after our answer is the old one, so wait for it to drop.
	always_ff @(posedge clk) begin
		valid <= 1'b0;
		data <= ~data;
		if (rst) begin
			cnt_q <= 4'h0;
			hold_q <= 1'b0;
			data <= 16'hA5A5;
		end else if (hold_q) begin
			hold_q <= req;
		end else if (req && cnt_q == lat) begin
			valid <= 1'b1;
			data <= word_in;
			cnt_q <= 4'h0;
			hold_q <= 1'b1;
		end else if (req) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule : core_mem_model
`default_nettype wire

// *** sim/effective_address_former_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module effective_address_former_tb;
	logic clk = 1'b0, rst = 1'b1, fetch = 1'b0, mem_valid, mode_set = 1'b0, mode_clr = 1'b0;
	logic interrupt = 1'b0, power_fail = 1'b0, panel_access = 1'b0, store_req = 1'b0;
	logic [15:0] instr = 16'h0000, x_reg = 16'h0000, mem_data, dp_hi = 16'h0000;
	logic [15:0] dp_lo = 16'h0000, ind_word = 16'h0000;
	logic [14:0] pc = 15'h0000, store_addr = 15'h0000, ea_q, ind_addr_q, vector_q;
	logic [3:0] lat = 4'h0, opcode_q;
	logic ea_valid_q, ind_req_q, lockout_err_q, store_ok_q, addr_extend_mode_ff;
	logic prior_mode_indicator, index_to_sum_enable, addr_reg_extra_bit, dp_ok_q;
	logic [5:0] shift_count_q;
	logic [30:0] dp_value_q;
	int miscompares = 0, total_checks = 0, cycles = 0;
	always #4 clk = ~clk;
	effective_address_former DUT (.clk(clk), .rst(rst), .fetch(fetch), .instr(instr), .pc(pc),
		.x_reg(x_reg), .mem_valid(mem_valid), .mem_data(mem_data), .mode_set(mode_set),
		.mode_clr(mode_clr), .interrupt(interrupt), .power_fail(power_fail),
		.panel_access(panel_access), .store_req(store_req), .store_addr(store_addr),
		.dp_hi(dp_hi), .dp_lo(dp_lo), .ea_q(ea_q), .ea_valid_q(ea_valid_q),
		.ind_req_q(ind_req_q), .ind_addr_q(ind_addr_q), .lockout_err_q(lockout_err_q),
		.store_ok_q(store_ok_q), .addr_extend_mode_ff(addr_extend_mode_ff),
		.prior_mode_indicator(prior_mode_indicator), .index_to_sum_enable(index_to_sum_enable),
		.addr_reg_extra_bit(addr_reg_extra_bit), .vector_q(vector_q), .opcode_q(opcode_q),
		.shift_count_q(shift_count_q), .dp_value_q(dp_value_q), .dp_ok_q(dp_ok_q));
	core_mem_model mem (.clk(clk), .rst(rst), .req(ind_req_q), .word_in(ind_word), .lat(lat),
		.valid(mem_valid), .data(mem_data));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Runs one address formation; exp_ind is checked when the first indirect word is asked for.
	task automatic ea_run(input logic [15:0] ins, input logic [14:0] p, input logic [15:0] x,
		input logic [14:0] exp_ind, input logic [14:0] exp);
		int n;
		n = 0;
		@(negedge clk);
		instr = ins;
		pc = p;
		x_reg = x;
		fetch = 1'b1;
		@(negedge clk);
		fetch = 1'b0;
		while (ea_valid_q !== 1'b1 && n < 40) begin
			if (ind_req_q === 1'b1 && n == 1) begin
				chk("ind_addr", ind_addr_q, exp_ind);
				chk("x_gate", index_to_sum_enable, 0);
			end
			@(negedge clk);
			n++;
		end
		chk("ea_valid", ea_valid_q, 1);
		chk("ea", ea_q, exp);
		@(negedge clk);
	endtask : ea_run
	task automatic ctl(input logic [3:0] v);
		@(negedge clk);
		{mode_set, mode_clr, interrupt, power_fail} = v;
		@(negedge clk);
		{mode_set, mode_clr, interrupt, power_fail} = 4'h0;
		@(negedge clk);
	endtask : ctl
	task automatic prot(input logic pa, input logic [14:0] a, input logic exp);
		@(negedge clk);
		panel_access = pa;
		store_addr = a;
		store_req = 1'b1;
		repeat (2) @(negedge clk);
		chk("store_ok", store_ok_q, exp);
		store_req = 1'b0;
	endtask : prot
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		chk("mode_rst", addr_extend_mode_ff, 0);
		ea_run(16'h05AB, 15'h0A00, 16'h0000, 15'h0000, 15'h01AB);
		ea_run(16'h0605, 15'h0A00, 16'h0000, 15'h0000, 15'h0A05);
		ea_run(16'h0605, 15'h4200, 16'h0000, 15'h0000, 15'h0205);
		ea_run(16'h4010, 15'h0A00, 16'h0005, 15'h0000, 15'h0015);
		ind_word = 16'h3100;
		lat = 4'h3;
		ea_run(16'h8020, 15'h0A00, 16'h0000, 15'h0020, 15'h3100);
		ctl(4'h8);
		chk("mode_set", addr_extend_mode_ff, 1);
		ind_word = 16'h4100;
		ea_run(16'hC020, 15'h0A00, 16'h0005, 15'h0020, 15'h4105);
		chk("x_gate_final", index_to_sum_enable, 1);
		lat = 4'h0;
		ea_run(16'h8020, 15'h0A00, 16'h0005, 15'h0020, 15'h4100);
		chk("x_gate_none", index_to_sum_enable, 0);
		ea_run(16'h4010, 15'h0A00, 16'h0007, 15'h0000, 15'h0017);
		ea_run(16'h0605, 15'h4200, 16'h0000, 15'h0000, 15'h4205);
		chk("extra_set", addr_reg_extra_bit, 1);
		ctl(4'h2);
		chk("prior_ext", prior_mode_indicator, 1);
		chk("vec_intr", vector_q, 15'h0033);
		ctl(4'h4);
		chk("mode_clr", addr_extend_mode_ff, 0);
		ea_run(16'h0605, 15'h0200, 16'h0000, 15'h0000, 15'h4205);
		chk("extra_hold", addr_reg_extra_bit, 1);
		@(negedge clk);
		power_fail = 1'b1;
		@(negedge clk);
		power_fail = 1'b0;
		chk("mode_int", addr_extend_mode_ff, 1);
		chk("prior_norm", prior_mode_indicator, 0);
		chk("vec_pfail", vector_q, 15'h0030);
		@(negedge clk);
		chk("vec_back", vector_q, 15'h0033);
		prot(1'b0, 15'h0001, 1'b0);
		prot(1'b0, 15'h000F, 1'b0);
		prot(1'b0, 15'h0010, 1'b1);
		prot(1'b1, 15'h0001, 1'b1);
		instr = 16'h3C3B;
		dp_hi = 16'h8001;
		dp_lo = 16'h7FFF;
		repeat (2) @(negedge clk);
		chk("opcode", opcode_q, 4'hF);
		chk("shift", shift_count_q, 6'h05);
		chk("dp_val", dp_value_q, 31'h4000FFFF);
		chk("dp_ok", dp_ok_q, 1);
		dp_lo = 16'h8000;
		repeat (2) @(negedge clk);
		chk("dp_bad", dp_ok_q, 0);
		wrap_up();
	end
endmodule : effective_address_former_tb
`default_nettype wire
